// ---- shared/ufc_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the frame-format block
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH

// Register addresses in the special-function register space
`define UFC_ADDR_DATA 8'h99
`define UFC_ADDR_FORMAT 8'ha9
`define UFC_ADDR_CTRL 8'h9a
`define UFC_ADDR_STAT 8'h9b

// Frame format register fields
`define UFC_FMT_MCE 7
`define UFC_FMT_PT_HI 6
`define UFC_FMT_PT_LO 5
`define UFC_FMT_PE 4
`define UFC_FMT_DL_HI 3
`define UFC_FMT_DL_LO 2
`define UFC_FMT_XBE 1
`define UFC_FMT_SBL 0
`define UFC_FMT_RESET 8'h0c

// Control register fields
`define UFC_CTL_TBX 3
`define UFC_CTL_RBX 2
`define UFC_CTL_TDONE 1
`define UFC_CTL_RDONE 0

// Status register fields
`define UFC_STA_PERR 6
`define UFC_STA_TIDLE 5

// Half bit time in system clocks
`define UFC_HALF_DIV 434

`endif

// ---- shared/ufc_pkg.sv ----
// Types shared by the frame-format block
package ufc_pkg;

	typedef enum logic [2:0] {
		UFC_IDLE = 3'b000,
		UFC_START = 3'b001,
		UFC_DATA = 3'b010,
		UFC_EXTRA = 3'b011,
		UFC_STOP = 3'b100,
		UFC_HOLD = 3'b101
	} ufc_state_t;

	typedef enum logic [1:0] {
		UFC_PAR_ODD = 2'b00,
		UFC_PAR_EVEN = 2'b01,
		UFC_PAR_MARK = 2'b10,
		UFC_PAR_SPACE = 2'b11
	} ufc_par_t;

	// One received word as it sits in the buffer
	typedef struct packed {
		logic perr;
		logic extra;
		logic [7:0] data;
	} ufc_rx_word_t;

endpackage

// ---- src/ufc_fifo.sv ----
// Small valid/ready buffer on the receive path
`timescale 1ns/1ps
module ufc_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 2
) (
	input wire logic clk_i, // System clock
	input wire logic reset_i, // Synchronous reset
	input wire logic in_valid_i, // Word offered
	output logic in_ready_i_o, // Room for a word
	input wire logic [WIDTH-1:0] in_data_i, // Offered word
	output logic out_valid_o, // Oldest word present
	input wire logic out_ready_i, // Oldest word taken
	output logic [WIDTH-1:0] out_data_o // Oldest word
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready_i_o = (cnt_r != FULL);
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o = mem_r[rp_r];
	assign push = in_valid_i && in_ready_i_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wp_nxt = (wp_r == LAST) ? '0 : wp_r + 1'b1;
		end
		if (pop) begin
			rp_nxt = (rp_r == LAST) ? '0 : rp_r + 1'b1;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
		if (push) begin
			mem_r[wp_r] <= in_data_i;
		end
	end
endmodule

// ---- src/ufc_uart_format.sv ----
// Serial port frame-format control with transmit and receive framing
`timescale 1ns/1ps
`include "ufc_cfg.svh"
module ufc_uart_format
	import ufc_pkg::*;
#(
	parameter int HALF_DIV = `UFC_HALF_DIV,
	parameter int RX_DEPTH = 2
) (
	input wire logic clk_i, // System clock, 100 MHz
	input wire logic reset_i, // Synchronous reset, active high
	input wire logic [7:0] sfr_addr_i, // Register address
	input wire logic sfr_wr_i, // Register write strobe
	input wire logic sfr_rd_i, // Register read strobe
	input wire logic [7:0] sfr_wdata_i, // Write data
	output logic [7:0] sfr_rdata_o, // Read data, cycle after strobe
	input wire logic irq_en_i, // Port interrupt enable
	output logic irq_o, // Interrupt request
	output logic txd_o, // Serial line out
	input wire logic rxd_i // Serial line in
);
	localparam logic [15:0] DIV_LAST = 16'(HALF_DIV - 1);

	////////////////////////////////////////////////////////////////////////////
	logic [7:0] fmt_r, fmt_nxt;
	logic tbx_r, tbx_nxt, rbx_r, rbx_nxt;
	logic tdone_r, tdone_nxt, rdone_r, rdone_nxt;
	logic perr_r, perr_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	logic wr_data, wr_fmt, wr_ctl, wr_sta, rd_data;
	logic pe, xbe, mce, sbl;
	ufc_par_t ptype;
	logic [2:0] last_bit;

	assign wr_data = sfr_wr_i && (sfr_addr_i == `UFC_ADDR_DATA);
	assign wr_fmt = sfr_wr_i && (sfr_addr_i == `UFC_ADDR_FORMAT);
	assign wr_ctl = sfr_wr_i && (sfr_addr_i == `UFC_ADDR_CTRL);
	assign wr_sta = sfr_wr_i && (sfr_addr_i == `UFC_ADDR_STAT);
	assign rd_data = sfr_rd_i && (sfr_addr_i == `UFC_ADDR_DATA);
	assign mce = fmt_r[`UFC_FMT_MCE];
	assign ptype = ufc_par_t'(fmt_r[`UFC_FMT_PT_HI:`UFC_FMT_PT_LO]);
	assign pe = fmt_r[`UFC_FMT_PE];
	assign xbe = fmt_r[`UFC_FMT_XBE];
	assign sbl = fmt_r[`UFC_FMT_SBL];
	assign last_bit = 3'd4 + {1'b0, fmt_r[`UFC_FMT_DL_HI:`UFC_FMT_DL_LO]};

	// Parity bit over the active data bits
	function automatic logic par_bit(input logic [7:0] d, input logic [2:0] lb,
			input ufc_par_t t);
		logic [7:0] m;
		logic x;
		m = 8'hff >> (3'd7 - lb);
		x = ^(d & m);
		case (t)
			UFC_PAR_ODD: par_bit = ~x;
			UFC_PAR_EVEN: par_bit = x;
			UFC_PAR_MARK: par_bit = 1'b1;
			UFC_PAR_SPACE: par_bit = 1'b0;
			default: par_bit = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Transmitter
	ufc_state_t tx_st_r, tx_st_nxt;
	logic [15:0] tx_div_r, tx_div_nxt;
	logic [1:0] tx_cnt_r, tx_cnt_nxt;
	logic [2:0] tx_bit_r, tx_bit_nxt;
	logic [7:0] tx_sh_r, tx_sh_nxt;
	logic tx_slot_r, tx_slot_nxt, txd_r, txd_nxt, tx_tick, tx_stop_enter;

	assign tx_tick = (tx_div_r == DIV_LAST);

	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_div_nxt = (tx_st_r == UFC_IDLE || tx_tick) ? 16'h0000 : tx_div_r + 16'h0001;
		tx_cnt_nxt = tx_cnt_r;
		tx_bit_nxt = tx_bit_r;
		tx_sh_nxt = tx_sh_r;
		tx_slot_nxt = tx_slot_r;
		txd_nxt = txd_r;
		tx_stop_enter = 1'b0;
		case (tx_st_r)
			UFC_IDLE: begin
				txd_nxt = 1'b1;
				if (wr_data) begin
					tx_st_nxt = UFC_START;
					txd_nxt = 1'b0;
					tx_cnt_nxt = 2'd1;
					tx_sh_nxt = sfr_wdata_i;
					tx_slot_nxt = pe ? par_bit(sfr_wdata_i, last_bit, ptype) : tbx_r;
				end
			end
			UFC_START, UFC_DATA, UFC_EXTRA, UFC_STOP: begin
				if (tx_tick) begin
					tx_cnt_nxt = tx_cnt_r - 2'd1;
					if (tx_cnt_r == 2'd0) begin
						tx_cnt_nxt = 2'd1;
						case (tx_st_r)
							UFC_START: begin
								tx_st_nxt = UFC_DATA;
								tx_bit_nxt = 3'd0;
								txd_nxt = tx_sh_r[0];
							end
							UFC_DATA: begin
								tx_sh_nxt = tx_sh_r >> 1;
								tx_bit_nxt = tx_bit_r + 3'd1;
								txd_nxt = tx_sh_r[1];
								if (tx_bit_r == last_bit) begin
									// Slot only with parity or extra bit
									if (pe || xbe) begin
										tx_st_nxt = UFC_EXTRA;
										txd_nxt = tx_slot_r;
									end else begin
										tx_stop_enter = 1'b1;
									end
								end
							end
							UFC_EXTRA: tx_stop_enter = 1'b1;
							default: tx_st_nxt = UFC_IDLE;
						endcase
						if (tx_stop_enter) begin
							tx_st_nxt = UFC_STOP;
							txd_nxt = 1'b1;
							// Stop length in half bits minus one
							tx_cnt_nxt = !sbl ? 2'd1 : (last_bit == 3'd4) ? 2'd2 : 2'd3;
						end
					end
				end
			end
			default: tx_st_nxt = UFC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_st_r <= UFC_IDLE;
			tx_div_r <= 16'h0000;
			tx_cnt_r <= 2'd0;
			tx_bit_r <= 3'd0;
			tx_sh_r <= 8'h00;
			tx_slot_r <= 1'b0;
			txd_r <= 1'b1;
		end else begin
			tx_st_r <= tx_st_nxt;
			tx_div_r <= tx_div_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_bit_r <= tx_bit_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_slot_r <= tx_slot_nxt;
			txd_r <= txd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receiver
	ufc_state_t rx_st_r, rx_st_nxt;
	logic [15:0] rx_div_r, rx_div_nxt;
	logic [1:0] rx_cnt_r, rx_cnt_nxt;
	logic [2:0] rx_bit_r, rx_bit_nxt;
	logic [7:0] rx_sh_r, rx_sh_nxt;
	logic rx_slot_r, rx_slot_nxt, rx_tick, rx_ok;
	ufc_rx_word_t rx_word_r, rx_word_nxt, head;
	logic push_valid, push_ready, pushed, head_valid, rx_stop_capture;

	assign rx_tick = (rx_div_r == DIV_LAST);
	assign pushed = push_valid && push_ready;
	// Stop high, extra high too when multiprocessor
	assign rx_ok = rxd_i && (!mce || (xbe && rx_slot_r));

	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_div_nxt = (rx_st_r == UFC_IDLE || rx_tick) ? 16'h0000 : rx_div_r + 16'h0001;
		rx_cnt_nxt = rx_cnt_r;
		rx_bit_nxt = rx_bit_r;
		rx_sh_nxt = rx_sh_r;
		rx_slot_nxt = rx_slot_r;
		rx_word_nxt = rx_word_r;
		push_valid = 1'b0;
		rx_stop_capture = 1'b0;
		case (rx_st_r)
			UFC_IDLE: begin
				if (!rxd_i) begin
					rx_st_nxt = UFC_START;
					rx_cnt_nxt = 2'd0;
					rx_sh_nxt = 8'h00;
				end
			end
			UFC_START, UFC_DATA, UFC_EXTRA, UFC_STOP: begin
				if (rx_tick) begin
					rx_cnt_nxt = rx_cnt_r - 2'd1;
					if (rx_cnt_r == 2'd0) begin
						rx_cnt_nxt = 2'd1;
						case (rx_st_r)
							UFC_START: begin
								// Start not still low at mid-bit is a glitch
								rx_st_nxt = rxd_i ? UFC_IDLE : UFC_DATA;
								rx_bit_nxt = 3'd0;
							end
							UFC_DATA: begin
								rx_sh_nxt[rx_bit_r] = rxd_i;
								rx_bit_nxt = rx_bit_r + 3'd1;
								if (rx_bit_r == last_bit) begin
									rx_st_nxt = (pe || xbe) ? UFC_EXTRA : UFC_STOP;
									rx_slot_nxt = 1'b0;
								end
							end
							UFC_EXTRA: begin
								rx_slot_nxt = rxd_i;
								rx_st_nxt = UFC_STOP;
							end
							default: begin
								rx_stop_capture = 1'b1;
								rx_word_nxt.data = rx_sh_r;
								rx_word_nxt.extra = rx_slot_r;
								rx_word_nxt.perr = pe &&
									(rx_slot_r != par_bit(rx_sh_r, last_bit, ptype));
								rx_st_nxt = rx_ok ? UFC_HOLD : UFC_IDLE;
							end
						endcase
					end
				end
			end
			UFC_HOLD: begin
				// Receiver waits here while the buffer is full
				push_valid = 1'b1;
				if (push_ready) begin
					rx_st_nxt = UFC_IDLE;
				end
			end
			default: rx_st_nxt = UFC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx_st_r <= UFC_IDLE;
			rx_div_r <= 16'h0000;
			rx_cnt_r <= 2'd0;
			rx_bit_r <= 3'd0;
			rx_sh_r <= 8'h00;
			rx_slot_r <= 1'b0;
			rx_word_r <= '0;
		end else begin
			rx_st_r <= rx_st_nxt;
			rx_div_r <= rx_div_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_slot_r <= rx_slot_nxt;
			rx_word_r <= rx_word_nxt;
		end
	end

	ufc_fifo #(
		.WIDTH($bits(ufc_rx_word_t)),
		.DEPTH(RX_DEPTH)
	) u_rx_fifo (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.in_valid_i(push_valid),
		.in_ready_i_o(push_ready),
		.in_data_i(rx_word_r),
		.out_valid_o(head_valid),
		.out_ready_i(rd_data),
		.out_data_o(head)
	);

	////////////////////////////////////////////////////////////////////////////
	// Registers and flags
	always_comb begin
		fmt_nxt = wr_fmt ? sfr_wdata_i : fmt_r;
		tbx_nxt = wr_ctl ? sfr_wdata_i[`UFC_CTL_TBX] : tbx_r;
		// Extra bit when enabled and parity off, else first stop level
		rbx_nxt = rbx_r;
		if (rx_stop_capture) begin
			rbx_nxt = (xbe && !pe) ? rx_slot_r : rxd_i;
		end
		// Cleared only by software, hardware set wins
		tdone_nxt = wr_ctl ? sfr_wdata_i[`UFC_CTL_TDONE] : tdone_r;
		if (tx_stop_enter) begin
			tdone_nxt = 1'b1;
		end
		rdone_nxt = wr_ctl ? sfr_wdata_i[`UFC_CTL_RDONE] : rdone_r;
		// Held while any word is buffered
		if (pushed || head_valid) begin
			rdone_nxt = 1'b1;
		end
		perr_nxt = wr_sta ? sfr_wdata_i[`UFC_STA_PERR] : perr_r;
		// Oldest buffered word carries the error
		if (head_valid && head.perr) begin
			perr_nxt = 1'b1;
		end
		irq_nxt = irq_en_i && (tdone_r || rdone_r);
		rdata_nxt = 8'h00;
		if (sfr_rd_i) begin
			case (sfr_addr_i)
				`UFC_ADDR_DATA: rdata_nxt = head_valid ? head.data : 8'h00;
				`UFC_ADDR_FORMAT: rdata_nxt = fmt_r;
				`UFC_ADDR_CTRL: rdata_nxt = {4'h0, tbx_r, rbx_r, tdone_r, rdone_r};
				`UFC_ADDR_STAT: rdata_nxt = {1'b0, perr_r, tx_st_r == UFC_IDLE, 5'h00};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fmt_r <= `UFC_FMT_RESET;
			tbx_r <= 1'b0;
			rbx_r <= 1'b0;
			tdone_r <= 1'b0;
			rdone_r <= 1'b0;
			perr_r <= 1'b0;
			irq_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			fmt_r <= fmt_nxt;
			tbx_r <= tbx_nxt;
			rbx_r <= rbx_nxt;
			tdone_r <= tdone_nxt;
			rdone_r <= rdone_nxt;
			perr_r <= perr_nxt;
			irq_r <= irq_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign sfr_rdata_o = rdata_r;
	assign irq_o = irq_r;
	assign txd_o = txd_r;
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the frame-format block
`timescale 1ns/1ps
`include "ufc_cfg.svh"
module tb_top;
	localparam int H = 4;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic irq, txd, rxd;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) cyc++;

	ufc_uart_format #(.HALF_DIV(H), .RX_DEPTH(2)) dut (.clk_i(clk_i), .reset_i(reset_i),
		.sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
		.sfr_rdata_o(rdata), .irq_en_i(en), .irq_o(irq), .txd_o(txd), .rxd_i(rxd));
	ufc_peer #(.HALF_DIV(H)) peer (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		if (n_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i) #1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk_i) #1;
		wr = 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i) #1;
		addr = a;
		rd = 1'b1;
		@(posedge clk_i) #1;
		rd = 1'b0;
		d = rdata;
	endtask

	function automatic logic [7:0] dmask(input logic [7:0] f, input logic [7:0] d);
		return d & (8'hff >> (3 - f[3:2]));
	endfunction

	// Whole frame, start first; n gets the bit count
	function automatic logic [11:0] frm(input logic [7:0] f, input logic [7:0] d,
		input logic x, output int n);
		logic [7:0] dm;
		logic p;
		dm = dmask(f, d);
		case (f[6:5])
			2'b00: p = ~^dm;
			2'b01: p = ^dm;
			2'b10: p = 1'b1;
			default: p = 1'b0;
		endcase
		frm = {3'b000, dm, 1'b0};
		n = f[3:2] + 6;
		if (f[4] || f[1]) begin
			frm[n] = f[4] ? p : x;
			n++;
		end
		frm[n] = 1'b1;
		n++;
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] f, d, v;
		logic [11:0] b, e;
		logic x, ok;
		int n, c, m, s;
		void'($urandom(32'hd0c6));
		repeat (16) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		rd_reg(`UFC_ADDR_FORMAT, v);
		chk(v, `UFC_FMT_RESET);
		rd_reg(8'h00, v);
		chk(v, 8'h00);
		// Every length and parity type on transmit
		for (int i = 0; i < 16; i++) begin
			f = 8'($urandom);
			f[7] = 1'b0;
			f[6:5] = 2'(i >> 2);
			f[3:2] = 2'(i);
			d = 8'($urandom);
			x = 1'($urandom_range(1));
			en = 1'($urandom_range(1));
			wr_reg(`UFC_ADDR_CTRL, {4'h0, x, 3'b000});
			wr_reg(`UFC_ADDR_FORMAT, f);
			e = frm(f, d, x, n);
			repeat (110) @(posedge clk_i);
			wr_reg(`UFC_ADDR_DATA, d);
			c = cyc;
			fork
				peer.recv(n, b);
				begin
					rd_reg(`UFC_ADDR_CTRL, v);
					chk(v[1], 1'b0);
					do rd_reg(`UFC_ADDR_STAT, v);
					while (v[5] !== 1'b1 && cyc - c < 400);
				end
			join
			m = cyc - c;
			s = f[0] ? (f[3:2] == 2'b00 ? 3 * H : 4 * H) : 2 * H;
			s = s + (n - 1) * 2 * H;
			chk(m >= s && m <= s + 5, 1'b1);
			chk(b, e);
			rd_reg(`UFC_ADDR_CTRL, v);
			chk(v[1], 1'b1);
			chk(irq, en);
			wr_reg(`UFC_ADDR_CTRL, 8'h00);
			repeat (2) @(posedge clk_i);
			#1;
			chk(irq, 1'b0);
		end
		// Random receive formats, bad stop or parity among them
		for (int i = 0; i < 24; i++) begin
			f = 8'($urandom);
			d = 8'($urandom);
			x = 1'($urandom_range(1));
			c = $urandom_range(3);
			wr_reg(`UFC_ADDR_CTRL, 8'h00);
			wr_reg(`UFC_ADDR_STAT, 8'h00);
			wr_reg(`UFC_ADDR_FORMAT, f);
			e = frm(f, d, x, n);
			if (c == 0)
				e[n - 1] = 1'b0;
			if (c == 1 && f[4])
				e[n - 2] = ~e[n - 2];
			peer.send(e, n);
			repeat (2 * H) @(posedge clk_i);
			// Multiprocessor: slot bit as received must be high
			ok = e[n - 1] && (!f[7] || (f[1] && e[n - 2]));
			rd_reg(`UFC_ADDR_CTRL, v);
			chk({v[2], v[0]}, {(f[1] && !f[4]) ? x : e[n - 1], ok});
			rd_reg(`UFC_ADDR_STAT, v);
			chk(v[6], ok && f[4] && c == 1);
			rd_reg(`UFC_ADDR_DATA, v);
			chk(v, ok ? dmask(f, d) : 8'h00);
			rd_reg(`UFC_ADDR_STAT, v);
			chk(v[6], ok && f[4] && c == 1);
			wr_reg(`UFC_ADDR_CTRL, 8'h00);
			rd_reg(`UFC_ADDR_CTRL, v);
			chk(v[0], 1'b0);
		end
		// Three frames unread: buffer full, receiver holds the last
		en = 1'b1;
		wr_reg(`UFC_ADDR_FORMAT, `UFC_FMT_RESET);
		for (int i = 0; i < 3; i++) begin
			e = frm(`UFC_FMT_RESET, 8'h5a + 8'(i), 1'b0, n);
			peer.send(e, n);
		end
		repeat (4 * H) @(posedge clk_i);
		wr_reg(`UFC_ADDR_CTRL, 8'h00);
		rd_reg(`UFC_ADDR_CTRL, v);
		chk(v[0], 1'b1);
		chk(irq, 1'b1);
		for (int i = 0; i < 4; i++) begin
			rd_reg(`UFC_ADDR_DATA, v);
			chk(v, i < 3 ? 8'h5a + 8'(i) : 8'h00);
		end
		stop_test();
	end

	initial begin
		repeat (60000) @(posedge clk_i);
		n_errors++;
		stop_test();
	end
endmodule

bind ufc_uart_format ufc_uart_monitor #(.HALF_DIV(HALF_DIV)) mon (.clk_i(clk_i),
	.reset_i(reset_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
	.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .irq_en_i(irq_en_i),
	.irq_o(irq_o), .txd_o(txd_o), .rxd_i(rxd_i));

// ---- verification/ufc_peer.sv ----
// Remote serial transceiver model
`timescale 1ns/1ps
module ufc_peer #(
	parameter int HALF_DIV = 4
) (
	input wire logic clk_i, // System clock
	input wire logic txd_i, // Line from the block
	output logic rxd_o // Line into the block
);
	initial rxd_o = 1'b1;

	// Start, data LSB first, stop
	// Last bit cut short past mid-bit so a low stop cannot fake a start
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i) #1;
			rxd_o = bits[i];
			repeat ((i == n - 1) ? HALF_DIV + 2 : 2 * HALF_DIV - 1) @(posedge clk_i);
		end
		@(posedge clk_i) #1;
		rxd_o = 1'b1;
	endtask

	task automatic recv(input int n, output logic [11:0] bits);
		bits = 12'h000;
		@(posedge clk_i);
		while (txd_i) @(posedge clk_i);
		repeat (HALF_DIV) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			bits[i] = txd_i;
			repeat (2 * HALF_DIV) @(posedge clk_i);
		end
	endtask
endmodule

// ---- verification/ufc_uart_monitor.sv ----
// Port-level assertions for the frame-format block
`timescale 1ns/1ps
`include "ufc_cfg.svh"
module ufc_uart_monitor #(
	parameter int HALF_DIV = 434
) (
	input wire logic clk_i, // System clock
	input wire logic reset_i, // Synchronous reset
	input wire logic [7:0] sfr_addr_i, // Register address
	input wire logic sfr_wr_i, // Write strobe
	input wire logic sfr_rd_i, // Read strobe
	input wire logic [7:0] sfr_wdata_i, // Write data
	input wire logic [7:0] sfr_rdata_o, // Read data
	input wire logic irq_en_i, // Interrupt enable
	input wire logic irq_o, // Interrupt request
	input wire logic txd_o, // Serial out
	input wire logic rxd_i // Serial in
);
	// Longest high run inside a frame is 22 half bits
	localparam int LIM = 26 * HALF_DIV;
	logic [15:0] hi_cnt_r, hi_cnt_nxt, lo_cnt_r, lo_cnt_nxt;
	logic [7:0] fmt_r, fmt_nxt;

	always_comb begin
		hi_cnt_nxt = txd_o ? hi_cnt_r + {15'h0000, hi_cnt_r != 16'hffff} : 16'h0000;
		lo_cnt_nxt = !txd_o ? lo_cnt_r + {15'h0000, lo_cnt_r != 16'hffff} : 16'h0000;
		fmt_nxt = (sfr_wr_i && sfr_addr_i == `UFC_ADDR_FORMAT) ? sfr_wdata_i : fmt_r;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			hi_cnt_r <= 16'h0000;
			lo_cnt_r <= 16'h0000;
			fmt_r <= `UFC_FMT_RESET;
		end else begin
			hi_cnt_r <= hi_cnt_nxt;
			lo_cnt_r <= lo_cnt_nxt;
			fmt_r <= fmt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	AST_IRQ_EN: assert property (!$past(irq_en_i) |-> !irq_o)
		else $error("interrupt without enable");
	AST_FLAG_HOLD: assert property (irq_o && irq_en_i && !$past(sfr_wr_i) |=> irq_o)
		else $error("done flag dropped without a write");
	AST_TX_START: assert property (sfr_wr_i && sfr_addr_i == `UFC_ADDR_DATA &&
		hi_cnt_r > LIM |=> !txd_o)
		else $error("no start bit after data write");
	AST_TX_CAUSE: assert property ($fell(txd_o) && hi_cnt_r > LIM |->
		$past(sfr_wr_i && sfr_addr_i == `UFC_ADDR_DATA))
		else $error("frame started without data write");
	AST_LOW_RUN: assert property ($rose(txd_o) |-> lo_cnt_r >= 2 * HALF_DIV - 1)
		else $error("low level shorter than a bit");
	AST_HIGH_RUN: assert property ($fell(txd_o) |-> hi_cnt_r >= 2 * HALF_DIV - 1)
		else $error("high level shorter than a bit");
	AST_FMT_READ: assert property ($past(sfr_rd_i && sfr_addr_i == `UFC_ADDR_FORMAT) |->
		sfr_rdata_o == $past(fmt_r))
		else $error("format read mismatch");
	AST_RESET_IDLE: assert property ($fell(reset_i) |->
		txd_o && !irq_o && sfr_rdata_o == 8'h00)
		else $error("outputs not idle after reset");

	cover property ($fell(txd_o) && hi_cnt_r > LIM);
	cover property ($rose(irq_o));
	cover property ($past(sfr_rd_i && sfr_addr_i == `UFC_ADDR_DATA) && sfr_rdata_o != 8'h00);
endmodule
